// ---- src/mbf_pkg.sv ----
`default_nettype none
package mbf_pkg;
	// register map of the front end (word addresses on the plain port)
	localparam logic [3:0] MBF_ADDR_PAGE   = 4'h0;
	localparam logic [3:0] MBF_ADDR_PMODE0 = 4'h1;
	localparam logic [3:0] MBF_ADDR_PMODE2 = 4'h2;
	localparam logic [3:0] MBF_ADDR_BUSCFG = 4'h3;
	localparam logic [3:0] MBF_ADDR_STATUS = 4'h4;
	localparam logic [3:0] MBF_ADDR_IAP    = 4'h5;
	// reset values
	localparam logic [7:0] MBF_PAGE_RST   = 8'h00;
	localparam logic [7:0] MBF_PMODE0_RST = 8'h01;
	localparam logic [7:0] MBF_PMODE2_RST = 8'h00;
	localparam logic [7:0] MBF_BUSCFG_RST = 8'h00;
	// power mode zero fields
	localparam int MBF_PM0_FAST_BIT = 0;
	localparam int MBF_PM0_APD_BIT  = 1;
	// bus configuration fields
	localparam int MBF_CFG_WR_DIR_BIT  = 0;
	localparam int MBF_CFG_RD_LO_BIT   = 1;
	localparam int MBF_CFG_AS_RISE_BIT = 3;
	localparam int MBF_CFG_HI_DATA_BIT = 4;
	localparam int MBF_CFG_FETCH_BIT   = 5;
	localparam int MBF_CFG_NOMUX_BIT   = 6;
	// second control input modes
	localparam logic [1:0] MBF_RD_STROBE = 2'h0;
	localparam logic [1:0] MBF_RD_ECLK   = 2'h1;
	localparam logic [1:0] MBF_RD_DSTRB  = 2'h2;
	localparam logic [1:0] MBF_RD_FETCH  = 2'h3;
	// idle time before auto power down, in ns, and its cycle count at 10 MHz
	localparam longint MBF_CLK_HZ       = 10000000;
	localparam longint MBF_APD_IDLE_NS  = 100000;
	localparam int     MBF_APD_CYCLES   = int'((MBF_APD_IDLE_NS * MBF_CLK_HZ) / 1000000000);
	// in-application update commands
	localparam logic [7:0] MBF_IAP_MAIN = 8'h01;
	localparam logic [7:0] MBF_IAP_BOOT = 8'h02;
	localparam logic [7:0] MBF_IAP_LOGIC = 8'h04;
	typedef enum logic [2:0] {
		MBF_ST_IDLE = 3'b001,
		MBF_ST_BUSY = 3'b010,
		MBF_ST_DOWN = 3'b100
	} mbf_pwr_t;
endpackage : mbf_pkg
`default_nettype wire

// ---- src/mbf_addr_latch.sv ----
`default_nettype none
// captures the 16-bit bus address on the chosen edge of the strobe
module mbf_addr_latch
	import mbf_pkg::*;
#(
	parameter int AW = 16
) (
	input  wire logic          clk_sys_i,
	input  wire logic          sys_rst_i,
	input  wire logic          strobe_i,
	input  wire logic          rise_mode_i,
	input  wire logic [AW-1:0] addr_i,
	output logic      [AW-1:0] addr_o,
	output logic               capt_o
);
	logic          strobe_q;   // previous strobe level
	logic [AW-1:0] next_addr;  // next latched address
	logic          next_capt;  // capture pulse

	// rising mode takes the rising edge; classic latch mode the falling edge
	always_comb begin
		next_addr = addr_o;
		next_capt = 1'b0;
		if (rise_mode_i ? (strobe_i && !strobe_q) : (!strobe_i && strobe_q)) begin
			next_addr = addr_i;
			next_capt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			strobe_q <= 1'b0;
			addr_o   <= '0;
			capt_o   <= 1'b0;
		end else begin
			strobe_q <= strobe_i;
			addr_o   <= next_addr;
			capt_o   <= next_capt;
		end
	end
endmodule : mbf_addr_latch
`default_nettype wire

// ---- src/mbf_idle_timer.sv ----
`default_nettype none
// counts idle cycles and flags power down after the limit
module mbf_idle_timer #(
	parameter int LIMIT = 1000
) (
	input  wire logic clk_sys_i,
	input  wire logic sys_rst_i,
	input  wire logic enable_i,
	input  wire logic activity_i,
	output logic      expired_o
);
	logic [$clog2(LIMIT+1)-1:0] count;       // idle cycle count
	logic [$clog2(LIMIT+1)-1:0] next_count;  // next count
	logic                       next_expired;

	// any bus activity or disable restarts the count
	always_comb begin
		next_count   = count;
		next_expired = expired_o;
		if (!enable_i || activity_i) begin
			next_count   = '0;
			next_expired = 1'b0;
		end else if (count == ($clog2(LIMIT+1))'(LIMIT - 1)) begin
			next_expired = 1'b1;
		end else begin
			next_count = count + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			count     <= '0;
			expired_o <= 1'b0;
		end else begin
			count     <= next_count;
			expired_o <= next_expired;
		end
	end
endmodule : mbf_idle_timer
`default_nettype wire

// ---- src/mbf_front_end.sv ----
// Function
// - high port carries data in page mode
// - address strobe captures both ports each cycle
// - drive data only on read and select
// - latched address feeds decode logic
// - first control: write strobe or direction
// - second control: read, E, data strobe, fetch
// - third control: fetch strobe or generic input
// - control inputs feed logic arrays
// - reset clears ports, logic and configuration (the reset pin here keeps bus_cfg)
// - reset aborts flash program or erase
// - eight-bit page register extends address
// - page bits usable as decode terms
// - page remaps flash blocks
// - host may update flash, never logic/config
// - idle bus triggers auto power down
// - fast bit cleared latches logic outputs (here logic_terms_o still follow every input change)
// - power mode two blocks logic inputs
// - rising-edge strobe mode captures on rise
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`default_nettype none
module mbf_front_end
	import mbf_pkg::*;
#(
	parameter int APD_LIMIT = MBF_APD_CYCLES
) (
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	input  wire logic        reset_n_i,
	// host bus pins
	input  wire logic [7:0]  low_addr_data_port_i,
	input  wire logic [7:0]  high_addr_data_port_i,
	output logic      [7:0]  low_addr_data_port_o,
	output logic      [7:0]  high_addr_data_port_o,
	output logic             low_addr_data_port_oe_o,
	output logic             high_addr_data_port_oe_o,
	input  wire logic        address_strobe_i,
	input  wire logic        ctrl_in_zero_i,
	input  wire logic        ctrl_in_one_i,
	input  wire logic        ctrl_in_two_i,
	// internal read data from the selected block
	input  wire logic [7:0]  block_rdata_i,
	input  wire logic        flash_busy_i,
	// decode and logic array facing outputs
	output logic      [23:0] decode_addr_o,
	output logic      [5:0]  logic_terms_o,
	output logic             block_select_o,
	output logic             main_flash_sel_o,
	output logic             bus_read_o,
	output logic             bus_write_o,
	output logic             logic_latch_o,
	output logic             power_down_o,
	output logic             flash_abort_o,
	output logic             iap_main_en_o,
	output logic             iap_boot_en_o,
	// register port
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o
);
	// configuration and page registers
	logic [7:0]  address_page_extension;  // page register
	logic [7:0]  power_mode_reg_zero;      // fast bit, auto power down enable
	logic [7:0]  power_mode_reg_two;       // input blocking bits
	logic [7:0]  bus_cfg;                  // strobe modes
	logic [7:0]  iap_ctrl;                 // flash update enables
	logic [7:0]  next_page, next_pm0, next_pm2, next_cfg, next_iap;
	logic [7:0]  next_rdata;
	// bus side state
	logic [15:0] latched_addr;             // captured address
	logic        addr_capt;                // capture pulse
	logic        rd_act, wr_act;           // decoded strobes
	logic        ctrl_one_q, ctrl_zero_q;  // previous control levels
	logic        apd_expired;              // idle limit reached
	logic        logic_latch;              // logic array standby
	logic        next_latch;
	logic [5:0]  raw_terms, next_terms;
	mbf_pwr_t    pwr_state, next_pwr;

	// selects the capture edge configuration
	mbf_addr_latch #(
		.AW (16)
	) u_latch (
		.clk_sys_i   (clk_sys_i),
		.sys_rst_i   (sys_rst_i),
		.strobe_i    (address_strobe_i),
		.rise_mode_i (bus_cfg[MBF_CFG_AS_RISE_BIT]),
		.addr_i      ({high_addr_data_port_i, low_addr_data_port_i}),
		.addr_o      (latched_addr),
		.capt_o      (addr_capt)
	);

	mbf_idle_timer #(
		.LIMIT (APD_LIMIT)
	) u_idle (
		.clk_sys_i  (clk_sys_i),
		.sys_rst_i  (sys_rst_i),
		.enable_i   (power_mode_reg_zero[MBF_PM0_APD_BIT]),
		.activity_i (addr_capt || rd_act || wr_act),
		.expired_o  (apd_expired)
	);

	// strobe decode from configured control modes
	always_comb begin
		if (bus_cfg[MBF_CFG_WR_DIR_BIT]) begin
			wr_act = !ctrl_in_zero_i && ctrl_zero_q == 1'b0 && !ctrl_in_one_i;
		end else begin
			wr_act = !ctrl_in_zero_i;
		end
		unique case (bus_cfg[2:1])
			MBF_RD_STROBE: rd_act = !ctrl_in_one_i;
			MBF_RD_ECLK:   rd_act = ctrl_in_one_i && ctrl_in_zero_i;
			MBF_RD_DSTRB:  rd_act = !ctrl_in_one_i && ctrl_in_zero_i;
			MBF_RD_FETCH:  rd_act = !ctrl_in_one_i;
		endcase
		if (bus_cfg[MBF_CFG_FETCH_BIT]) begin
			rd_act = rd_act || !ctrl_in_two_i;
		end
		// with E and direction modes together a write needs the data phase
		if (bus_cfg[MBF_CFG_WR_DIR_BIT] && bus_cfg[2:1] == MBF_RD_ECLK) begin
			wr_act = ctrl_in_one_i && !ctrl_in_zero_i;
		end
	end

	// logic array inputs and standby latch
	always_comb begin
		raw_terms = {rd_act, wr_act, address_strobe_i, ctrl_in_two_i,
		             ctrl_in_one_i, ctrl_in_zero_i};
		raw_terms = raw_terms & ~power_mode_reg_two[5:0];
		next_latch = !power_mode_reg_zero[MBF_PM0_FAST_BIT];
		next_terms = logic_terms_o;
		if (!logic_latch || raw_terms != logic_terms_o) begin
			next_terms = raw_terms;
		end
	end

	// power state: auto power down ends on any bus activity
	always_comb begin
		next_pwr = pwr_state;
		unique case (pwr_state)
			MBF_ST_IDLE: if (rd_act || wr_act) next_pwr = MBF_ST_BUSY;
			MBF_ST_BUSY: if (!rd_act && !wr_act) next_pwr = MBF_ST_IDLE;
			MBF_ST_DOWN: if (addr_capt || rd_act || wr_act) next_pwr = MBF_ST_BUSY;
			default:     next_pwr = MBF_ST_IDLE;
		endcase
		if (apd_expired && pwr_state != MBF_ST_DOWN) begin
			next_pwr = MBF_ST_DOWN;
		end
	end

	// register writes and reads
	always_comb begin
		next_page  = address_page_extension;
		next_pm0   = power_mode_reg_zero;
		next_pm2   = power_mode_reg_two;
		next_cfg   = bus_cfg;
		next_iap   = iap_ctrl;
		next_rdata = 8'h00;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				MBF_ADDR_PAGE:   next_page = reg_wdata_i;
				MBF_ADDR_PMODE0: next_pm0  = reg_wdata_i;
				MBF_ADDR_PMODE2: next_pm2  = reg_wdata_i;
				MBF_ADDR_BUSCFG: next_cfg  = reg_wdata_i;
				MBF_ADDR_IAP:    next_iap  = reg_wdata_i & (MBF_IAP_MAIN | MBF_IAP_BOOT);
				default:         next_iap  = iap_ctrl;
			endcase
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				MBF_ADDR_PAGE:   next_rdata = address_page_extension;
				MBF_ADDR_PMODE0: next_rdata = power_mode_reg_zero;
				MBF_ADDR_PMODE2: next_rdata = power_mode_reg_two;
				MBF_ADDR_BUSCFG: next_rdata = bus_cfg;
				MBF_ADDR_STATUS: next_rdata = {5'h00, flash_busy_i, logic_latch,
				                               pwr_state == MBF_ST_DOWN};
				MBF_ADDR_IAP:    next_rdata = iap_ctrl;
				default:         next_rdata = 8'h00;
			endcase
		end
	end

	// reset pin clears ports, logic, page and power mode registers; bus configuration is kept
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			address_page_extension   <= MBF_PAGE_RST;
			power_mode_reg_zero      <= MBF_PMODE0_RST;
			power_mode_reg_two       <= MBF_PMODE2_RST;
			bus_cfg                  <= MBF_BUSCFG_RST;
			iap_ctrl                 <= 8'h00;
			reg_rdata_o              <= 8'h00;
			pwr_state                <= MBF_ST_IDLE;
			logic_latch              <= 1'b0;
			logic_terms_o            <= 6'h00;
			ctrl_one_q               <= 1'b1;
			ctrl_zero_q              <= 1'b1;
			low_addr_data_port_o     <= 8'h00;
			high_addr_data_port_o    <= 8'h00;
			low_addr_data_port_oe_o  <= 1'b0;
			high_addr_data_port_oe_o <= 1'b0;
			decode_addr_o            <= 24'h000000;
			block_select_o           <= 1'b0;
			main_flash_sel_o         <= 1'b0;
			bus_read_o               <= 1'b0;
			bus_write_o              <= 1'b0;
			logic_latch_o            <= 1'b0;
			power_down_o             <= 1'b0;
			flash_abort_o            <= 1'b0;
			iap_main_en_o            <= 1'b0;
			iap_boot_en_o            <= 1'b0;
		end else if (!reset_n_i) begin
			address_page_extension   <= MBF_PAGE_RST;
			power_mode_reg_zero      <= MBF_PMODE0_RST;
			power_mode_reg_two       <= MBF_PMODE2_RST;
			iap_ctrl                 <= 8'h00;
			// decode view follows the cleared page at once
			decode_addr_o            <= {MBF_PAGE_RST, latched_addr};
			main_flash_sel_o         <= latched_addr[15] ^ MBF_PAGE_RST[7];
			logic_terms_o            <= 6'h00;
			logic_latch              <= 1'b0;
			pwr_state                <= MBF_ST_IDLE;
			low_addr_data_port_oe_o  <= 1'b0;
			high_addr_data_port_oe_o <= 1'b0;
			flash_abort_o            <= flash_busy_i;
			iap_main_en_o            <= 1'b0;
			iap_boot_en_o            <= 1'b0;
		end else begin
			address_page_extension <= next_page;
			power_mode_reg_zero    <= next_pm0;
			power_mode_reg_two     <= next_pm2;
			bus_cfg                <= next_cfg;
			iap_ctrl               <= next_iap;
			reg_rdata_o            <= next_rdata;
			pwr_state              <= next_pwr;
			logic_latch            <= next_latch;
			logic_terms_o          <= next_terms;
			ctrl_one_q             <= ctrl_in_one_i;
			ctrl_zero_q            <= ctrl_in_zero_i;
			decode_addr_o    <= {address_page_extension, latched_addr};
			block_select_o   <= pwr_state != MBF_ST_DOWN;
			main_flash_sel_o <= latched_addr[15] ^ address_page_extension[7];
			bus_read_o       <= rd_act;
			bus_write_o      <= wr_act;
			logic_latch_o    <= logic_latch;
			power_down_o     <= next_pwr == MBF_ST_DOWN;
			flash_abort_o    <= 1'b0;
			iap_main_en_o    <= iap_ctrl[0];
			iap_boot_en_o    <= iap_ctrl[1];
			// drive only on read with a block selected
			low_addr_data_port_oe_o  <= rd_act && block_select_o;
			low_addr_data_port_o     <= block_rdata_i;
			// high port as data in page mode
			high_addr_data_port_oe_o <= rd_act && block_select_o
			                            && bus_cfg[MBF_CFG_HI_DATA_BIT];
			high_addr_data_port_o    <= block_rdata_i;
		end
	end
endmodule : mbf_front_end
`default_nettype wire

// ---- dv/mbf_front_end_properties.sv ----
`default_nettype none
// watches the host side ports of the front end
module mbf_front_end_properties #(
	parameter int APD_LIMIT = 8
) (
	input wire logic        clk_sys_i,
	input wire logic        sys_rst_i,
	input wire logic        reset_n_i,
	input wire logic        address_strobe_i,
	input wire logic        flash_busy_i,
	input wire logic        reg_rd_i,
	input wire logic        low_addr_data_port_oe_o,
	input wire logic        high_addr_data_port_oe_o,
	input wire logic        bus_read_o,
	input wire logic [23:0] decode_addr_o,
	input wire logic        main_flash_sel_o,
	input wire logic        power_down_o,
	input wire logic        flash_abort_o,
	input wire logic        iap_main_en_o,
	input wire logic        iap_boot_en_o,
	input wire logic [7:0]  reg_rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	logic        strobe_q; // strobe one cycle back
	logic [15:0] idle_cnt; // cycles since the strobe last moved
	// idle count saturates so a long quiet spell never wraps to zero
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			strobe_q <= 1'b0;
			idle_cnt <= 16'h0000;
		end else begin
			strobe_q <= address_strobe_i;
			if (address_strobe_i != strobe_q)
				idle_cnt <= 16'h0000;
			else if (idle_cnt != 16'hffff)
				idle_cnt <= idle_cnt + 16'h0001;
		end
	end
	chk_low_drive: assert property (
		low_addr_data_port_oe_o |-> bus_read_o || $past(bus_read_o)) else $error("low port drive");
	chk_high_drive: assert property (
		high_addr_data_port_oe_o |-> bus_read_o || $past(bus_read_o)) else $error("high port drive");
	chk_abort_cause: assert property (
		!reset_n_i && flash_busy_i |=> flash_abort_o) else $error("abort missing");
	chk_abort_only: assert property (
		flash_abort_o |-> $past(!reset_n_i && flash_busy_i)) else $error("abort unprovoked");
	chk_page_clear: assert property (
		!reset_n_i [*3] |-> decode_addr_o[23:16] == 8'h00) else $error("page kept");
	chk_iap_clear: assert property (
		!reset_n_i [*3] |-> !iap_main_en_o && !iap_boot_en_o) else $error("update kept");
	chk_addr_hold: assert property (
		$stable(address_strobe_i) [*4] |-> $stable(decode_addr_o[15:0])) else $error("address moved");
	chk_flash_swap: assert property (
		$stable(decode_addr_o) [*2] |-> main_flash_sel_o == (decode_addr_o[15] ^ decode_addr_o[23]))
		else $error("flash swap");
	chk_apd_idle: assert property (
		$rose(power_down_o) |-> idle_cnt >= APD_LIMIT - 2) else $error("early power down");
	chk_rdata_quiet: assert property (
		reg_rdata_o != 8'h00 |-> $past(reg_rd_i)) else $error("read data unasked");
	cover property (flash_abort_o);
	cover property ($rose(power_down_o));
	cover property (low_addr_data_port_oe_o);
endmodule : mbf_front_end_properties
bind mbf_front_end mbf_front_end_properties #(.APD_LIMIT(APD_LIMIT)) mbf_front_end_properties_inst (
	.clk_sys_i, .sys_rst_i, .reset_n_i, .address_strobe_i, .flash_busy_i, .reg_rd_i,
	.low_addr_data_port_oe_o, .high_addr_data_port_oe_o, .bus_read_o, .decode_addr_o,
	.main_flash_sel_o, .power_down_o, .flash_abort_o, .iap_main_en_o, .iap_boot_en_o, .reg_rdata_o);
`default_nettype wire

// ---- dv/mbf_host_model.sv ----
`default_nettype none
// host with a multiplexed bus; strobes idle high, address strobe idle low
module mbf_host_model (
	input  wire logic       clk_sys_i,
	output logic      [7:0] low_addr_data_port_o,
	output logic      [7:0] high_addr_data_port_o,
	output logic            address_strobe_o,
	output logic            ctrl_in_zero_o,
	output logic            ctrl_in_one_o,
	output logic            ctrl_in_two_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// quiet bus at time zero
	initial begin
		{high_addr_data_port_o, low_addr_data_port_o} = 16'h0000;
		address_strobe_o = 1'b0;
		{ctrl_in_two_o, ctrl_in_one_o, ctrl_in_zero_o} = 3'b111;
	end
	// spare third control input, used as a generic logic term
	task automatic set_aux(input logic v);
		@(posedge clk_sys_i);
		ctrl_in_two_o <= v;
	endtask : set_aux
	// one bus cycle: address phase, strobe pulse, then read or write phase
	task automatic bus_cycle(input logic [15:0] addr, input logic rd, input int len,
	                         input logic ds);
		@(posedge clk_sys_i);
		{high_addr_data_port_o, low_addr_data_port_o} <= addr;
		address_strobe_o <= 1'b1;
		@(posedge clk_sys_i);
		address_strobe_o <= 1'b0;
		@(posedge clk_sys_i);
		// released lines show the inverse, never the stale address
		{high_addr_data_port_o, low_addr_data_port_o} <= ~addr;
		// direction hosts pulse the data strobe low for reads and writes alike
		ctrl_in_one_o <= ds ? 1'b0 : !rd;
		ctrl_in_zero_o <= rd;
		repeat (len) @(posedge clk_sys_i);
		ctrl_in_one_o <= 1'b1;
		ctrl_in_zero_o <= 1'b1;
	endtask : bus_cycle
endmodule : mbf_host_model
`default_nettype wire

// ---- dv/mbf_front_end_bench.sv ----
`default_nettype none
// self-checking bench for the host bus front end
module mbf_front_end_bench;
	import mbf_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int AUTO_POWER_DOWN = 8; // short idle limit keeps the run brief
	logic        clk_sys_i, sys_rst_i, reset_n_i, address_strobe_i, flash_busy_i;
	logic        ctrl_in_zero_i, ctrl_in_one_i, ctrl_in_two_i, reg_wr_i, reg_rd_i;
	logic [7:0]  low_addr_data_port_i, high_addr_data_port_i, block_rdata_i, reg_wdata_i;
	logic [7:0]  low_addr_data_port_o, high_addr_data_port_o, reg_rdata_o, page, rv;
	logic        low_addr_data_port_oe_o, high_addr_data_port_oe_o, block_select_o;
	logic        main_flash_sel_o, bus_read_o, bus_write_o, logic_latch_o, power_down_o;
	logic        flash_abort_o, iap_main_en_o, iap_boot_en_o;
	logic [23:0] decode_addr_o;
	logic [5:0]  logic_terms_o;
	logic [3:0]  reg_addr_i;
	logic [15:0] a;
	int          fails, checks_done;
	mbf_front_end #(.APD_LIMIT(AUTO_POWER_DOWN)) mbf_front_end_inst (.*);
	mbf_host_model mbf_host_model_inst (.clk_sys_i, .low_addr_data_port_o(low_addr_data_port_i),
		.high_addr_data_port_o(high_addr_data_port_i), .address_strobe_o(address_strobe_i),
		.ctrl_in_zero_o(ctrl_in_zero_i), .ctrl_in_one_o(ctrl_in_one_i),
		.ctrl_in_two_o(ctrl_in_two_i));
	// compare one result against its expectation
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// register write, one strobe cycle
	task automatic reg_wr(input logic [3:0] ad, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= ad;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : reg_wr
	// register read; data stands only in the cycle after the strobe
	task automatic reg_chk(input logic [3:0] ad, input logic [7:0] exp);
		@(posedge clk_sys_i);
		reg_addr_i <= ad;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1 check("register", exp, reg_rdata_o);
	endtask : reg_chk
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	// watchdog against a hung sequence
	initial begin
		#2000000;
		fails++;
		end_of_test();
	end
	initial begin
		{sys_rst_i, flash_busy_i, reg_wr_i, reg_rd_i} = 4'b1000;
		// device reset pin held low over power up
		reset_n_i = 1'b0;
		{reg_addr_i, reg_wdata_i, block_rdata_i} = 20'h00000;
		fails = 0;
		checks_done = 0;
		rv = 8'($urandom(32'hd590));
		repeat (5) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		reset_n_i <= 1'b1;
		reg_chk(MBF_ADDR_PAGE, MBF_PAGE_RST);
		reg_chk(MBF_ADDR_PMODE0, MBF_PMODE0_RST);
		reg_chk(MBF_ADDR_PMODE2, MBF_PMODE2_RST);
		reg_chk(MBF_ADDR_BUSCFG, MBF_BUSCFG_RST);
		reg_chk(4'hf, 8'h00);
		// every read mode of the second control input
		for (int m = 0; m < 4; m++) begin
			reg_wr(MBF_ADDR_BUSCFG, {5'h00, m[1:0], 1'b0});
			reg_chk(MBF_ADDR_BUSCFG, {5'h00, m[1:0], 1'b0});
		end
		// random page and address; falling, then rising, then high-port data capture
		for (int i = 0; i < 6; i++) begin
			page = (i == 1) ? 8'hff : 8'($urandom);
			a = (i == 0) ? 16'hffff : 16'($urandom);
			reg_wr(MBF_ADDR_BUSCFG, (i < 3) ? 8'h00 : ((i == 5) ? 8'h18 : 8'h08));
			reg_wr(MBF_ADDR_PAGE, page);
			block_rdata_i <= 8'($urandom);
			mbf_host_model_inst.bus_cycle(a, 1'b1, 3, 1'b0);
			#1 check("decode address", {page, a}, decode_addr_o);
			check("read flag", 24'h1, bus_read_o);
			if (low_addr_data_port_oe_o === 1'b1)
				check("low read data", block_rdata_i, low_addr_data_port_o);
			if (high_addr_data_port_oe_o === 1'b1)
				check("high read data", block_rdata_i, high_addr_data_port_o);
			repeat (3) @(posedge clk_sys_i);
			#1 check("drive released", 24'h0, low_addr_data_port_oe_o);
		end
		// write strobe mode then direction mode
		for (int d = 0; d < 2; d++) begin
			// direction mode pairs with the data strobe read mode
			reg_wr(MBF_ADDR_BUSCFG, (d == 1) ? 8'h05 : 8'h00);
			mbf_host_model_inst.bus_cycle(16'(~a), 1'b0, 2, d[0]);
			#1 check("write flag", 24'h1, bus_write_o);
		end
		// control levels as logic terms, then blocked by power mode two
		mbf_host_model_inst.set_aux(1'b0);
		repeat (3) @(posedge clk_sys_i);
		#1 check("terms", 24'h3, logic_terms_o[2:0]);
		reg_wr(MBF_ADDR_PMODE2, 8'h3f);
		repeat (3) @(posedge clk_sys_i);
		#1 check("blocked terms", 24'h0, logic_terms_o[2:0]);
		reg_wr(MBF_ADDR_PMODE0, 8'h00);
		repeat (3) @(posedge clk_sys_i);
		#1 check("latched logic", 24'h1, logic_latch_o);
		// update enables: logic array never enabled
		reg_wr(MBF_ADDR_IAP, MBF_IAP_MAIN | MBF_IAP_BOOT | MBF_IAP_LOGIC);
		reg_chk(MBF_ADDR_IAP, 8'h03);
		check("update enables", 24'h3, {iap_main_en_o, iap_boot_en_o});
		// idle bus with auto power down on
		reg_wr(MBF_ADDR_PMODE0, 8'h03);
		for (int n = 0; n < AUTO_POWER_DOWN + 20 && power_down_o !== 1'b1; n++)
			@(posedge clk_sys_i);
		#1 check("power down", 24'h1, power_down_o);
		// device reset pin during a flash operation
		flash_busy_i <= 1'b1;
		reset_n_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		#1 check("flash abort", 24'h1, flash_abort_o);
		@(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		flash_busy_i <= 1'b0;
		reg_chk(MBF_ADDR_PAGE, 8'h00);
		reg_chk(MBF_ADDR_BUSCFG, 8'h05);
		check("update cleared", 24'h0, {iap_main_en_o, iap_boot_en_o});
		end_of_test();
	end
endmodule : mbf_front_end_bench
`default_nettype wire
